// ==== hdl/port_pin_function_and_direction_select.sv ====
// Port A low pin function mux and port B direction register
// Functional notes
// [RULE1] Pin 11: GPIO or chip select 1
// [RULE2] Pin 10: GPIO or chip select 0
// [RULE3] Single-chip mode keeps bus functions as GPIO
// [RULE4] Pin 9: GPIO, timer D, interrupt 3
// [RULE5] Pin 8: GPIO, timer C, interrupt 2
// [RULE6] Pin 7: GPIO, timer B, chip select 3
// [RULE7] Pin 6: GPIO, timer A, chip select 2
// [RULE8] Pin 5: GPIO, serial1 clock, DMA1, interrupt 1
// [RULE9] Pin 4: GPIO or serial1 transmit
// [RULE10] Pin 3: GPIO or serial1 receive
// [RULE11] Pin 2: GPIO, serial0 clock, DMA0, interrupt 0
// [RULE12] Pin 1: GPIO or serial0 transmit
// [RULE13] Pin 0: GPIO or serial0 receive
// [RULE14] Reserved bits read zero; avoid code 11
// [RULE15] Port B direction: bits 9:0 writable
// [RULE16] GPIO port B pin drives when bit set
// [RULE17] Direction ignored for non-GPIO port B pins
// [RULE18] Direction clears only on power-on reset
// [RULE19] Second select clears only on power-on reset
// [RULE20] Operating mode overrides select fields
// [RULE21] Input functions disable driver, forward level
`timescale 1ns/100ps
`include "pin_mux_cfg.svh"
module port_pin_function_and_direction_select
  import pin_mux_pkg::*;
#(
  parameter int NPA = 12,  // Port A low pins handled here
  parameter int NPB = 10   // Port B pins
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic single_chip,
  input wire logic rom_disabled,
  input wire logic [NPA-1:0] pa_gpio_out,
  input wire logic [NPA-1:0] pa_gpio_dir,
  input wire logic [NPA-1:0] pa_pin_in,
  output logic [NPA-1:0] pa_pin_out,
  output logic [NPA-1:0] pa_pin_oe_n,
  input wire logic [3:0] chip_select_n,
  input wire logic serial0_transmit,
  input wire logic serial1_transmit,
  input wire logic serial0_clock_out,
  input wire logic serial0_clock_drive,
  input wire logic serial1_clock_out,
  input wire logic serial1_clock_drive,
  output logic serial0_clock,
  output logic serial1_clock,
  output logic serial0_receive,
  output logic serial1_receive,
  output logic [3:0] timer_clock_in,
  output logic [3:0] ext_interrupt,
  output logic [1:0] dma_request,
  input wire logic [NPB-1:0] pb_gpio_mode,
  input wire logic [NPB-1:0] pb_gpio_out,
  input wire logic [NPB-1:0] pb_func_out,
  input wire logic [NPB-1:0] pb_func_drive,
  output logic [NPB-1:0] pb_pin_out,
  output logic [NPB-1:0] pb_pin_oe_n
);
  // All register state of the block
  typedef struct packed {
    reg16_t pa1;  // First low port A select
    reg16_t pa2;  // Second low port A select
    reg16_t pb_dir;  // Port B direction
  } regs_s;
  regs_s r;
  regs_s next_r;
  logic [3:0] reg_wr;  // Write strobes per register
  logic [15:0] wr_data;  // Write data, low half
  logic [15:0] wr_mask;  // Byte-lane mask
  logic [3:0][15:0] rd_words;  // Read-back words
  pin_kind_e pa_kind [NPA];  // Owner of each port A pin
  pin_kind_e pb_kind [NPB];  // Owner of each port B pin
  logic [NPA-1:0] fn_out;  // Peripheral output per pin
  logic [NPA-1:0] fn_drive;  // Peripheral drive per pin
  logic [NPA-1:0] routed;  // Pin not on GPIO
  logic bus_ok;  // External bus functions allowed
  logic rom_force;  // Chip selects 0 and 1 forced on
  logic sel11;  // Pin 11 field
  logic sel10;  // Pin 10 field
  logic [1:0] sel9;  // Pin 9 field
  logic [1:0] sel8;  // Pin 8 field
  logic [1:0] sel7;  // Pin 7 field
  logic [1:0] sel6;  // Pin 6 field
  logic [1:0] sel5;  // Pin 5 field
  logic sel4;  // Pin 4 field
  logic sel3;  // Pin 3 field
  logic [1:0] sel2;  // Pin 2 field
  logic sel1;  // Pin 1 field
  logic sel0;  // Pin 0 field

  // Bus slave front end
  apb_reg_port #(
    .NREG(4)
  ) u_apb (
    .pclk(pclk),
    .presetn(presetn),
    .paddr(paddr),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .reg_wr(reg_wr),
    .wr_data(wr_data),
    .wr_mask(wr_mask),
    .rd_words(rd_words)
  );

  // Read-back; status word shows routing and mode pins
  assign rd_words[0] = r.pa1;
  assign rd_words[1] = r.pa2;
  assign rd_words[2] = r.pb_dir;
  assign rd_words[3] = {2'b00, rom_disabled, single_chip, routed};

  // Masked writes keep reserved bits at zero [RULE14] [RULE15]
  always_comb begin
    logic [15:0] m;
    m = '0;
    next_r = r;
    if (reg_wr[0]) begin
      m = wr_mask & `MASK_PA_SEL1;
      next_r.pa1 = (r.pa1 & ~m) | (wr_data & m);
    end
    if (reg_wr[1]) begin
      m = wr_mask & `MASK_PA_SEL2;
      next_r.pa2 = (r.pa2 & ~m) | (wr_data & m);
    end
    if (reg_wr[2]) begin
      m = wr_mask & `MASK_PB_DIR;
      next_r.pb_dir = (r.pb_dir & ~m) | (wr_data & m);
    end
  end

  // Only the power-on reset clears these; other resets never reach
  // this block, so settings survive them [RULE18] [RULE19]
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r.pa1 <= `RST_PA_SEL1;
      r.pa2 <= `RST_PA_SEL2;
      r.pb_dir <= `RST_PB_DIR;
    end else begin
      r <= next_r;
    end
  end

  // Field extraction
  assign sel11 = r.pa1[`POS_P11];
  assign sel10 = r.pa1[`POS_P10];
  assign sel9 = r.pa1[`POS_P9+:2];
  assign sel8 = r.pa1[`POS_P8+:2];
  assign sel7 = r.pa2[`POS_P7+:2];
  assign sel6 = r.pa2[`POS_P6+:2];
  assign sel5 = r.pa2[`POS_P5+:2];
  assign sel4 = r.pa2[`POS_P4];
  assign sel3 = r.pa2[`POS_P3];
  assign sel2 = r.pa2[`POS_P2+:2];
  assign sel1 = r.pa2[`POS_P1];
  assign sel0 = r.pa2[`POS_P0];

  // Mode beats fields; single chip wins over ROM-disabled [RULE20]
  assign bus_ok = ~single_chip;  // [RULE3]
  assign rom_force = bus_ok & rom_disabled;

  // Owner of each port A pin; reserved codes fall back to GPIO
  always_comb begin
    for (int i = 0; i < NPA; i++) begin
      pa_kind[i] = kind_gpio;
    end
    // Chip selects forced in ROM-disabled mode [RULE1] [RULE2] [RULE3]
    if (rom_force | (bus_ok & sel11)) begin
      pa_kind[11] = kind_out;
    end
    if (rom_force | (bus_ok & sel10)) begin
      pa_kind[10] = kind_out;
    end
    // Timer or interrupt inputs [RULE4] [RULE5]
    if ((sel9 == `CODE_F1) | (sel9 == `CODE_F2)) begin
      pa_kind[9] = kind_in;
    end
    if ((sel8 == `CODE_F1) | (sel8 == `CODE_F2)) begin
      pa_kind[8] = kind_in;
    end
    // Timer input or chip select [RULE6] [RULE7] [RULE3]
    case (sel7)
      `CODE_F1: pa_kind[7] = kind_in;
      `CODE_F2: pa_kind[7] = bus_ok ? kind_out : kind_gpio;
      default: pa_kind[7] = kind_gpio;
    endcase
    case (sel6)
      `CODE_F1: pa_kind[6] = kind_in;
      `CODE_F2: pa_kind[6] = bus_ok ? kind_out : kind_gpio;
      default: pa_kind[6] = kind_gpio;
    endcase
    // Serial clock, DMA request, interrupt [RULE8] [RULE11] [RULE3]
    case (sel5)
      `CODE_F1: pa_kind[5] = kind_bidir;
      `CODE_F2: pa_kind[5] = bus_ok ? kind_in : kind_gpio;
      `CODE_F3: pa_kind[5] = kind_in;
      default: pa_kind[5] = kind_gpio;
    endcase
    case (sel2)
      `CODE_F1: pa_kind[2] = kind_bidir;
      `CODE_F2: pa_kind[2] = bus_ok ? kind_in : kind_gpio;
      `CODE_F3: pa_kind[2] = kind_in;
      default: pa_kind[2] = kind_gpio;
    endcase
    // Serial data pins [RULE9] [RULE10] [RULE12] [RULE13]
    if (sel4) begin
      pa_kind[4] = kind_out;
    end
    if (sel3) begin
      pa_kind[3] = kind_in;
    end
    if (sel1) begin
      pa_kind[1] = kind_out;
    end
    if (sel0) begin
      pa_kind[0] = kind_in;
    end
  end

  // Peripheral output values and drive enables per pin
  always_comb begin
    fn_out = '0;
    fn_drive = '1;
    fn_out[11] = chip_select_n[1];
    fn_out[10] = chip_select_n[0];
    fn_out[7] = chip_select_n[3];
    fn_out[6] = chip_select_n[2];
    fn_out[5] = serial1_clock_out;
    fn_drive[5] = serial1_clock_drive;
    fn_out[4] = serial1_transmit;
    fn_out[2] = serial0_clock_out;
    fn_drive[2] = serial0_clock_drive;
    fn_out[1] = serial0_transmit;
  end

  // One mux cell per port A pin
  for (genvar i = 0; i < NPA; i++) begin : g_pa
    assign routed[i] = (pa_kind[i] != kind_gpio);
    pin_route_cell u_cell (
      .kind(pa_kind[i]),
      .gpio_out(pa_gpio_out[i]),
      .gpio_dir(pa_gpio_dir[i]),
      .fn_out(fn_out[i]),
      .fn_drive(fn_drive[i]),
      .pin_out(pa_pin_out[i]),
      .pin_oe_n(pa_pin_oe_n[i])
    );
  end

  // Forward pin levels; unselected inputs idle high [RULE21]
  assign timer_clock_in[3] = (sel9 == `CODE_F1) ? pa_pin_in[9] : 1'b1;
  assign ext_interrupt[3] = (sel9 == `CODE_F2) ? pa_pin_in[9] : 1'b1;
  assign timer_clock_in[2] = (sel8 == `CODE_F1) ? pa_pin_in[8] : 1'b1;
  assign ext_interrupt[2] = (sel8 == `CODE_F2) ? pa_pin_in[8] : 1'b1;
  assign timer_clock_in[1] = (sel7 == `CODE_F1) ? pa_pin_in[7] : 1'b1;
  assign timer_clock_in[0] = (sel6 == `CODE_F1) ? pa_pin_in[6] : 1'b1;
  assign serial1_clock = (sel5 == `CODE_F1) ? pa_pin_in[5] : 1'b1;
  assign dma_request[1] = (bus_ok & (sel5 == `CODE_F2)) ? pa_pin_in[5] : 1'b1;
  assign ext_interrupt[1] = (sel5 == `CODE_F3) ? pa_pin_in[5] : 1'b1;
  assign serial1_receive = sel3 ? pa_pin_in[3] : 1'b1;
  assign serial0_clock = (sel2 == `CODE_F1) ? pa_pin_in[2] : 1'b1;
  assign dma_request[0] = (bus_ok & (sel2 == `CODE_F2)) ? pa_pin_in[2] : 1'b1;
  assign ext_interrupt[0] = (sel2 == `CODE_F3) ? pa_pin_in[2] : 1'b1;
  assign serial0_receive = sel0 ? pa_pin_in[0] : 1'b1;

  // Port B: direction counts only on GPIO pins [RULE16] [RULE17]
  for (genvar j = 0; j < NPB; j++) begin : g_pb
    assign pb_kind[j] = pb_gpio_mode[j] ? kind_gpio : kind_bidir;
    pin_route_cell u_cell (
      .kind(pb_kind[j]),
      .gpio_out(pb_gpio_out[j]),
      .gpio_dir(r.pb_dir[j]),
      .fn_out(pb_func_out[j]),
      .fn_drive(pb_func_drive[j]),
      .pin_out(pb_pin_out[j]),
      .pin_oe_n(pb_pin_oe_n[j])
    );
  end

  // Checks, all on the one clock
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // Full-word write to the direction register
  sequence s_pb_write;
    psel && penable && pwrite && paddr == `OFS_PB_DIR && pstrb[1:0] == 2'b11;
  endsequence
  // Read setup of the direction register, then its access
  sequence s_pb_read;
    psel && !penable && !pwrite && paddr == `OFS_PB_DIR ##1 psel && penable;
  endsequence

  a_pb_write_takes: assert property ( // [RULE15]
    s_pb_write |=> r.pb_dir == {6'h00, $past(pwdata[9:0])})
    else $error("direction write not stored");
  a_pb_read_upper: assert property ( // [RULE15]
    s_pb_read |-> prdata[31:10] == 22'h000000)
    else $error("direction upper bits not zero");
  a_rsv_zero: assert property ( // [RULE14]
    (r.pa1 & ~`MASK_PA_SEL1) == 16'h0000 && (r.pa2 & ~`MASK_PA_SEL2) == 16'h0000)
    else $error("reserved select bits set");
  a_cs1_rom_force: assert property ( // [RULE1]
    !single_chip && rom_disabled |-> !pa_pin_oe_n[11] && pa_pin_out[11] == chip_select_n[1])
    else $error("chip select 1 not forced");
  a_cs0_select: assert property ( // [RULE2]
    !single_chip && sel10 |-> !pa_pin_oe_n[10] && pa_pin_out[10] == chip_select_n[0])
    else $error("chip select 0 not routed");
  a_single_gpio: assert property ( // [RULE3]
    single_chip && sel7 == `CODE_F2 |-> pa_pin_oe_n[7] == !pa_gpio_dir[7] && dma_request == 2'b11)
    else $error("bus function active in single chip");
  a_pin9_timer: assert property ( // [RULE4]
    sel9 == `CODE_F1 |-> pa_pin_oe_n[9] && timer_clock_in[3] == pa_pin_in[9] && ext_interrupt[3])
    else $error("pin 9 timer routing");
  a_pin8_irq: assert property ( // [RULE5]
    sel8 == `CODE_F2 |-> pa_pin_oe_n[8] && ext_interrupt[2] == pa_pin_in[8])
    else $error("pin 8 interrupt routing");
  a_pin6_cs2: assert property ( // [RULE7]
    !single_chip && sel6 == `CODE_F2 |-> !pa_pin_oe_n[6] && pa_pin_out[6] == chip_select_n[2])
    else $error("pin 6 chip select routing");
  a_pin5_dma: assert property ( // [RULE8]
    !single_chip && sel5 == `CODE_F2 |-> pa_pin_oe_n[5] && dma_request[1] == pa_pin_in[5])
    else $error("pin 5 dma routing");
  a_pin4_tx: assert property ( // [RULE9]
    $rose(sel4) |-> !pa_pin_oe_n[4] && pa_pin_out[4] == serial1_transmit)
    else $error("pin 4 transmit routing");
  a_pb_gpio_dir: assert property ( // [RULE16]
    reg_wr[2] && wr_mask[0] && pb_gpio_mode[0] |=> pb_pin_oe_n[0] == !$past(wr_data[0]))
    else $error("port B direction not applied");
  a_pb_func_dir: assert property ( // [RULE17]
    !pb_gpio_mode[4] |-> pb_pin_oe_n[4] == !pb_func_drive[4] && pb_pin_out[4] == pb_func_out[4])
    else $error("direction leaks into function");
endmodule : port_pin_function_and_direction_select

// ==== hdl/pin_mux_cfg.svh ====
// Register map, field positions and reset values of the pin mux
`ifndef PIN_MUX_CFG_SVH
`define PIN_MUX_CFG_SVH
// Byte offsets on the register bus
`define OFS_PA_SEL1 12'h000
`define OFS_PA_SEL2 12'h004
`define OFS_PB_DIR 12'h008
`define OFS_ROUTE_STAT 12'h00c
// Power-on reset values
`define RST_PA_SEL1 16'h0000
`define RST_PA_SEL2 16'h0000
`define RST_PB_DIR 16'h0000
// Writable bits; all others read as zero
`define MASK_PA_SEL1 16'h005f
`define MASK_PA_SEL2 16'hfd75
`define MASK_PB_DIR 16'h03ff
// Field positions, first select register
`define POS_P11 6
`define POS_P10 4
`define POS_P9 2
`define POS_P8 0
// Field positions, second select register
`define POS_P7 14
`define POS_P6 12
`define POS_P5 10
`define POS_P4 8
`define POS_P3 6
`define POS_P2 4
`define POS_P1 2
`define POS_P0 0
// Two-bit field codes
`define CODE_GPIO 2'b00
`define CODE_F1 2'b01
`define CODE_F2 2'b10
`define CODE_F3 2'b11
`endif

// ==== hdl/pin_mux_pkg.sv ====
// Types shared by the pin mux modules
package pin_mux_pkg;
  // What currently owns a pin
  typedef enum logic [1:0] {
    kind_gpio = 2'b00,  // Port register drives or listens
    kind_out = 2'b01,   // Peripheral output, always driven
    kind_in = 2'b10,    // Peripheral input, driver off
    kind_bidir = 2'b11  // Peripheral decides direction
  } pin_kind_e;
  // One register word
  typedef logic [15:0] reg16_t;
endpackage : pin_mux_pkg

// ==== hdl/pin_route_cell.sv ====
// Output and enable selection for one shared pin
`timescale 1ns/100ps
module pin_route_cell
  import pin_mux_pkg::*;
(
  input wire pin_kind_e kind,
  input wire logic gpio_out,
  input wire logic gpio_dir,
  input wire logic fn_out,
  input wire logic fn_drive,
  output logic pin_out,
  output logic pin_oe_n
);
  // Pure mux, no state: a pin follows its owner at once
  always_comb begin
    case (kind)
      // Direction bit only counts here
      kind_gpio: begin
        pin_out = gpio_out;
        pin_oe_n = ~gpio_dir;
      end
      kind_out: begin
        pin_out = fn_out;
        pin_oe_n = 1'b0;
      end
      // Input function keeps driver off
      kind_in: begin
        pin_out = 1'b0;
        pin_oe_n = 1'b1;
      end
      kind_bidir: begin
        pin_out = fn_out;
        pin_oe_n = ~fn_drive;
      end
      default: begin
        pin_out = gpio_out;
        pin_oe_n = ~gpio_dir;
      end
    endcase
  end
endmodule : pin_route_cell

// ==== hdl/apb_reg_port.sv ====
// APB slave front end: decode, write strobes, registered read data
`timescale 1ns/100ps
`include "pin_mux_cfg.svh"
module apb_reg_port
  import pin_mux_pkg::*;
#(
  parameter int NREG = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [NREG-1:0] reg_wr,
  output logic [15:0] wr_data,
  output logic [15:0] wr_mask,
  input wire logic [NREG-1:0][15:0] rd_words
);
  // Register state
  typedef struct packed {
    logic [31:0] rdata;  // Read data, loaded in setup
  } port_s;
  port_s r;
  port_s next_r;
  logic [NREG-1:0] hit;  // One-hot address decode
  logic [15:0] rd_mux;  // Selected read word
  logic access;  // Access phase of a transfer

  // Decode against the fixed map
  always_comb begin
    hit = '0;
    hit[0] = (paddr == `OFS_PA_SEL1);
    hit[1] = (paddr == `OFS_PA_SEL2);
    hit[2] = (paddr == `OFS_PB_DIR);
    hit[3] = (paddr == `OFS_ROUTE_STAT);
    rd_mux = '0;
    for (int i = 0; i < NREG; i++) begin
      if (hit[i]) begin
        rd_mux = rd_mux | rd_words[i];
      end
    end
  end

  // Zero wait states; unmapped addresses answer with an error
  assign access = psel & penable;
  assign pready = 1'b1;
  assign pslverr = access & ~(|hit);
  assign reg_wr = (access & pwrite) ? hit : '0;
  assign wr_data = pwdata[15:0];
  assign wr_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign prdata = r.rdata;

  // Read data captured in setup so it comes from a flip-flop
  always_comb begin
    next_r = r;
    if (psel & ~penable) begin
      next_r.rdata = pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
    end
  end

  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end
endmodule : apb_reg_port

// ==== test/pad_model.sv ====
// External pad model for the shared port A pins
`timescale 1ns/100ps
module pad_model #(
  parameter int N = 12  // Pins modelled
) (
  input wire logic [N-1:0] pin_out,
  input wire logic [N-1:0] pin_oe_n,
  input wire logic [N-1:0] ext_val,
  input wire logic [N-1:0] ext_en,
  output logic [N-1:0] pin_in
);
  // Wire level per pin: block driver first, then the outside device,
  // else the board pull-up; a released line never keeps its old value
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (!pin_oe_n[i]) begin
        pin_in[i] = pin_out[i];  // Driven pin reads its own level
      end else if (ext_en[i]) begin
        pin_in[i] = ext_val[i];  // Level forwarded to peripherals
      end else begin
        pin_in[i] = 1'b1;  // Pull-up
      end
    end
  end
endmodule : pad_model

// ==== test/testbench.sv ====
// Self-checking bench for the port pin mux and direction register
`timescale 1ns/100ps
`include "pin_mux_cfg.svh"
module testbench;
  // Bus and mode inputs
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, single_chip, rom_disabled;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic [3:0] pstrb, chip_select_n, timer_clock_in, ext_interrupt;
  // Port A pins and pad side
  logic [11:0] pa_gpio_out, pa_gpio_dir, pa_pin_in, pa_pin_out, pa_pin_oe_n, ext_val, ext_en;
  logic serial0_transmit, serial1_transmit, serial0_clock_out, serial0_clock_drive;
  logic serial1_clock_out, serial1_clock_drive, serial0_clock, serial1_clock;
  logic serial0_receive, serial1_receive, rerr;
  logic [1:0] dma_request;
  // Port B pins
  logic [9:0] pb_gpio_mode, pb_gpio_out, pb_func_out, pb_func_drive, pb_pin_out, pb_pin_oe_n;
  int n_fail, checked;
  localparam logic [11:0] PAT = 12'h6c9;  // Outside pin levels

  port_pin_function_and_direction_select dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .single_chip(single_chip), .rom_disabled(rom_disabled),
    .pa_gpio_out(pa_gpio_out), .pa_gpio_dir(pa_gpio_dir), .pa_pin_in(pa_pin_in),
    .pa_pin_out(pa_pin_out), .pa_pin_oe_n(pa_pin_oe_n), .chip_select_n(chip_select_n),
    .serial0_transmit(serial0_transmit), .serial1_transmit(serial1_transmit),
    .serial0_clock_out(serial0_clock_out), .serial0_clock_drive(serial0_clock_drive),
    .serial1_clock_out(serial1_clock_out), .serial1_clock_drive(serial1_clock_drive),
    .serial0_clock(serial0_clock), .serial1_clock(serial1_clock),
    .serial0_receive(serial0_receive), .serial1_receive(serial1_receive),
    .timer_clock_in(timer_clock_in), .ext_interrupt(ext_interrupt), .dma_request(dma_request),
    .pb_gpio_mode(pb_gpio_mode), .pb_gpio_out(pb_gpio_out), .pb_func_out(pb_func_out),
    .pb_func_drive(pb_func_drive), .pb_pin_out(pb_pin_out), .pb_pin_oe_n(pb_pin_oe_n)
  );

  pad_model pads (
    .pin_out(pa_pin_out), .pin_oe_n(pa_pin_oe_n), .ext_val(ext_val), .ext_en(ext_en),
    .pin_in(pa_pin_in)
  );

  // Free-running 20 MHz clock
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Verdict and end of run
  task automatic end_of_test;
    if (n_fail == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_of_test

  // Compare and count
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  // One APB transfer; waits on pready with a bound, never on a fixed latency
  task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] d, input logic [3:0] s);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {16'hffff, d};  // Upper half must be ignored
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      n_fail++;
      end_of_test();
    end
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [15:0] d);
    apb(1'b1, a, d, 4'h3);
  endtask : wr

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] e, input string n);
    apb(1'b0, a, 16'h0000, 4'h0);
    chk(n, rdat, {16'h0000, e});
  endtask : rd_chk

  // Let register updates reach the pins
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask : settle

  // Power-on state: all zero, every pin plain GPIO
  task automatic t_reset;
    rd_chk(`OFS_PA_SEL1, 16'h0000, "sel1_rst");
    rd_chk(`OFS_PA_SEL2, 16'h0000, "sel2_rst");
    rd_chk(`OFS_PB_DIR, 16'h0000, "dir_rst");
    rd_chk(`OFS_ROUTE_STAT, 16'h0000, "stat_rst");
    chk("pa_out_rst", pa_pin_out, pa_gpio_out);
    chk("pa_oe_rst", pa_pin_oe_n, {~pa_gpio_dir});
  endtask : t_reset

  // Reserved bits, byte strobes and an unmapped address
  task automatic t_masks;
    wr(`OFS_PA_SEL1, 16'hffff);
    wr(`OFS_PA_SEL2, 16'hffff);
    wr(`OFS_PB_DIR, 16'hffff);
    rd_chk(`OFS_PA_SEL1, 16'h005f, "sel1_mask");
    rd_chk(`OFS_PA_SEL2, 16'hfd75, "sel2_mask");
    rd_chk(`OFS_PB_DIR, 16'h03ff, "dir_mask");
    apb(1'b1, 12'h010, 16'hffff, 4'hf);
    chk("unmapped_err", rerr, 1);
    apb(1'b1, `OFS_PA_SEL2, 16'h0000, 4'h1);
    rd_chk(`OFS_PA_SEL2, 16'hfd00, "sel2_strobe");
    wr(`OFS_PA_SEL1, 16'h0000);
    wr(`OFS_PA_SEL2, 16'h0000);
    wr(`OFS_PB_DIR, 16'h0000);
  endtask : t_masks

  // Code 01 and single-bit functions on every pin
  task automatic t_func1;
    wr(`OFS_PA_SEL1, 16'h0055);
    wr(`OFS_PA_SEL2, 16'h5555);
    settle();
    chk("tclk", timer_clock_in, {PAT[9], PAT[8], PAT[7], PAT[6]});
    chk("rx", {serial1_receive, serial0_receive}, {PAT[3], PAT[0]});
    chk("cs01", pa_pin_out[11:10], chip_select_n[1:0]);
    chk("tx", {pa_pin_out[4], pa_pin_out[1]}, {serial1_transmit, serial0_transmit});
    chk("sck", {serial1_clock, serial0_clock, pa_pin_out[5]}, {serial1_clock_out, PAT[2], serial1_clock_out});
    chk("oe1", pa_pin_oe_n, 12'h3cd);
    chk("idle_in", {ext_interrupt, dma_request}, 6'h3f);
  endtask : t_func1

  // Code 10 on every two-bit field; stored value also masked
  task automatic t_func2;
    wr(`OFS_PA_SEL1, 16'h000a);
    wr(`OFS_PA_SEL2, 16'haaaa);
    settle();
    chk("irq32", ext_interrupt[3:2], {PAT[9], PAT[8]});
    chk("dma", dma_request, {PAT[5], PAT[2]});
    chk("cs23", pa_pin_out[7:6], chip_select_n[3:2]);
    chk("oe2", pa_pin_oe_n[9:2], 8'hcb);
    rd_chk(`OFS_PA_SEL2, 16'ha820, "sel2_rb");
  endtask : t_func2

  // Code 11: interrupts on pins 5 and 2, reserved elsewhere
  task automatic t_func3;
    wr(`OFS_PA_SEL1, 16'h000f);
    wr(`OFS_PA_SEL2, 16'hfc30);
    settle();
    chk("irq10", ext_interrupt, {2'b11, PAT[5], PAT[2]});
    chk("rsv_gpio", pa_pin_out[9:6], pa_gpio_out[9:6]);
    chk("rsv_tclk", timer_clock_in, 4'hf);
  endtask : t_func3

  // Mode overrides: single chip first, then ROM disabled
  task automatic t_mode;
    single_chip <= 1'b1;
    wr(`OFS_PA_SEL1, 16'h0050);
    wr(`OFS_PA_SEL2, 16'ha820);
    settle();
    chk("sc_cs", {pa_pin_out[11:10], pa_pin_out[7:6]}, {pa_gpio_out[11:10], pa_gpio_out[7:6]});
    chk("sc_dma", dma_request, 2'b11);
    rd_chk(`OFS_ROUTE_STAT, 16'h1000, "sc_stat");
    single_chip <= 1'b0;
    rom_disabled <= 1'b1;
    wr(`OFS_PA_SEL1, 16'h0000);
    settle();
    chk("rom_cs", pa_pin_out[11:10], chip_select_n[1:0]);
    rd_chk(`OFS_ROUTE_STAT, 16'h2ce4, "rom_stat");
    rom_disabled <= 1'b0;
    wr(`OFS_PA_SEL2, 16'h0000);
  endtask : t_mode

  // Port B direction, GPIO and non-GPIO pins
  task automatic t_portb;
    wr(`OFS_PB_DIR, 16'h0155);
    settle();
    chk("pb_oe", pb_pin_oe_n, {~10'h155});
    chk("pb_out", pb_pin_out, pb_gpio_out);
    @(posedge pclk);
    pb_gpio_mode <= 10'h30f;
    settle();
    chk("pb_oe_mix", pb_pin_oe_n, {(~10'h155 & 10'h30f) | (~pb_func_drive & ~10'h30f)});
    chk("pb_out_mix", pb_pin_out, {(pb_gpio_out & 10'h30f) | (pb_func_out & ~10'h30f)});
  endtask : t_portb

  // Values hold until a power-on reset clears them
  task automatic t_reset_mid;
    wr(`OFS_PA_SEL2, 16'h0141);
    repeat (20) @(posedge pclk);
    rd_chk(`OFS_PA_SEL2, 16'h0141, "sel2_hold");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(`OFS_PA_SEL2, 16'h0000, "sel2_por");
    rd_chk(`OFS_PB_DIR, 16'h0000, "dir_por");
  endtask : t_reset_mid

  // Main sequence; every input has a value at time zero
  initial begin
    n_fail = 0;
    checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h0;
    single_chip = 1'b0;
    rom_disabled = 1'b0;
    pa_gpio_out = 12'h663;
    pa_gpio_dir = 12'h0f0;
    ext_val = PAT;
    ext_en = 12'hfff;
    chip_select_n = 4'b1010;
    serial0_transmit = 1'b1;
    serial1_transmit = 1'b0;
    serial0_clock_out = 1'b1;
    serial0_clock_drive = 1'b0;
    serial1_clock_out = 1'b0;
    serial1_clock_drive = 1'b1;
    pb_gpio_mode = 10'h3ff;
    pb_gpio_out = 10'h2b6;
    pb_func_out = 10'h0c3;
    pb_func_drive = 10'h3a5;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_masks();
    t_func1();
    t_func2();
    t_func3();
    t_mode();
    t_portb();
    t_reset_mid();
    end_of_test();
  end

  // Hang guard
  initial begin
    #2000000;
    n_fail++;
    end_of_test();
  end
endmodule : testbench
